// ==== core/srq_pkg.sv ====
// package: command codes, field positions and reset values of the service request logic
package srq_pkg;

  // ****************************************
  // command codes
  // ****************************************
  typedef enum logic [2:0] {
    CMD_MASK_WR_ALL = 3'h0,
    CMD_MASK_WR_BIT = 3'h1,
    CMD_MASK_RD_ALL = 3'h2,
    CMD_MASK_RD_BIT = 3'h3,
    CMD_EVT_RD_ALL  = 3'h4,
    CMD_EVT_RD_BIT  = 3'h5
  } cmd_t;

  // ****************************************
  // summary status bit positions
  // ****************************************
  localparam int unsigned PROC_BIT = 0;
  localparam int unsigned ERR_BIT = 1;
  localparam int unsigned GAUGE_BIT = 2;
  localparam int unsigned EVENT_BIT = 5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] SUMMARY_RESET = 8'h00;

endpackage

// ==== core/event_status_if.sv ====
// interface: set, clear and value of the standard event status register
interface event_status_if;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [7:0] value;
  modport owner (input set_bits, input clr_bits, output value);
  modport user (output set_bits, output clr_bits, input value);
endinterface

// ==== core/event_status_store.sv ====
// module: standard event status register with set-over-clear bits
module event_status_store (
  input wire logic ref_clk,
  input wire logic sys_rst,
  event_status_if.owner evt
);

  logic [7:0] value_reg;
  logic [7:0] value_next;

  // a bit set in the cycle it is read stays set, so no event is lost
  always_comb begin
    value_next = (value_reg & ~evt.clr_bits) | evt.set_bits;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      value_reg <= srq_pkg::EVENT_RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  assign evt.value = value_reg;

  a_evt_set_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (evt.set_bits != 8'h00) |=> ((value_reg & $past(evt.set_bits)) == $past(evt.set_bits)))
    else $error("event set lost against clear");

endmodule // event_status_store

// ==== core/service_request.sv ====
// module: service request enable mask, summary status and request line
// Function
// - whole write loads the enable mask
// - bit write changes one mask bit
// - whole query returns the enable mask
// - bit query returns one mask bit
// - enabled summary bit raises service request
// - serial poll drops the service request
// - one request per summary bit until cleared
// - summary bit clears only with its source
// - whole query returns event status value
// - bit query returns one event bit
// - summary bits map to four status sources
// - event queries clear whole register or bit
module service_request (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire srq_pkg::cmd_t cmd_op,
  input wire logic [2:0] cmd_index,
  input wire logic [7:0] cmd_data,
  input wire logic process_control_summary,
  input wire logic error_summary,
  input wire logic gauge_summary,
  input wire logic [7:0] event_set,
  input wire logic serial_poll,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [7:0] summary_status,
  output logic service_request_out
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] bit_sel(input logic [2:0] idx);
    bit_sel = 8'h01 << idx;
  endfunction

  function automatic logic [7:0] one_bit(input logic [7:0] word, input logic [2:0] idx);
    one_bit = {7'h00, word[idx]};
  endfunction

  // ****************************************
  // event status register
  // ****************************************
  event_status_if evt ();

  event_status_store u_evt (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .evt(evt)
  );

  logic [7:0] evt_clr;

  always_comb begin
    evt_clr = 8'h00;
    if (cmd_valid && cmd_op == srq_pkg::CMD_EVT_RD_ALL) begin
      evt_clr = 8'hff;
    end else if (cmd_valid && cmd_op == srq_pkg::CMD_EVT_RD_BIT) begin
      evt_clr = bit_sel(cmd_index);
    end
  end

  assign evt.set_bits = event_set;
  assign evt.clr_bits = evt_clr;

  // ****************************************
  // enable mask and query answers
  // ****************************************
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic rsp_valid_reg;
  logic rsp_valid_next;
  logic [7:0] rsp_data_reg;
  logic [7:0] rsp_data_next;

  always_comb begin
    mask_next = mask_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    if (cmd_valid) begin
      case (cmd_op)
        srq_pkg::CMD_MASK_WR_ALL: begin
          mask_next = cmd_data;
        end
        srq_pkg::CMD_MASK_WR_BIT: begin
          mask_next = cmd_data[0] ? (mask_reg | bit_sel(cmd_index))
                                  : (mask_reg & ~bit_sel(cmd_index));
        end
        srq_pkg::CMD_MASK_RD_ALL: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = mask_reg;
        end
        srq_pkg::CMD_MASK_RD_BIT: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = one_bit(mask_reg, cmd_index);
        end
        srq_pkg::CMD_EVT_RD_ALL: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = evt.value;
        end
        srq_pkg::CMD_EVT_RD_BIT: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = one_bit(evt.value, cmd_index);
        end
        default: begin
          rsp_valid_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= srq_pkg::MASK_RESET;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      mask_reg <= mask_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  // ****************************************
  // summary status and service request
  // ****************************************
  logic [7:0] summary_reg;
  logic [7:0] summary_next;
  logic [7:0] used_reg;
  logic [7:0] used_next;
  logic srq_reg;
  logic srq_next;
  logic [7:0] fire;

  // summary follows its sources; it has no clear of its own
  always_comb begin
    summary_next = 8'h00;
    summary_next[srq_pkg::PROC_BIT] = process_control_summary;
    summary_next[srq_pkg::ERR_BIT] = error_summary;
    summary_next[srq_pkg::GAUGE_BIT] = gauge_summary;
    summary_next[srq_pkg::EVENT_BIT] = |evt.value;
  end

  // fire uses the live mask, so enabling an already set bit requests at once
  always_comb begin
    fire = summary_reg & mask_reg & ~used_reg;
    used_next = summary_reg & (used_reg | fire);
    // a new cause in the poll cycle keeps the request up
    srq_next = (|fire) | (srq_reg & ~serial_poll);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      summary_reg <= srq_pkg::SUMMARY_RESET;
      used_reg <= 8'h00;
      srq_reg <= 1'b0;
    end else begin
      summary_reg <= summary_next;
      used_reg <= used_next;
      srq_reg <= srq_next;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign summary_status = summary_reg;
  assign service_request_out = srq_reg;

  // ****************************************
  // assertions
  // ****************************************
  a_mask_whole_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && cmd_op == srq_pkg::CMD_MASK_WR_ALL) |=> (mask_reg == $past(cmd_data)))
    else $error("mask not loaded by whole write");

  a_mask_bit_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && cmd_op == srq_pkg::CMD_MASK_WR_BIT) |=>
      (mask_reg[$past(cmd_index)] == $past(cmd_data[0])) &&
      ((mask_reg & ~bit_sel($past(cmd_index))) == ($past(mask_reg) & ~bit_sel($past(cmd_index)))))
    else $error("mask bit write wrong");

  a_mask_query_all: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && cmd_op == srq_pkg::CMD_MASK_RD_ALL) |=> rsp_valid && (rsp_data == $past(mask_reg)))
    else $error("mask query answer wrong");

  a_mask_query_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && cmd_op == srq_pkg::CMD_MASK_RD_BIT) |=>
      rsp_valid && (rsp_data == {7'h00, $past(mask_reg[cmd_index])}))
    else $error("mask bit query answer wrong");

  a_srq_raise: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (|(summary_reg & mask_reg & ~used_reg)) |=> service_request_out)
    else $error("service request not raised");

  a_poll_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (serial_poll && !(|fire)) |=> !service_request_out)
    else $error("serial poll did not drop request");

  a_no_second_request: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!service_request_out && (fire == 8'h00)) |=> !service_request_out)
    else $error("request raised without new cause");

  a_used_follows_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> ((used_reg & ~$past(summary_reg)) == 8'h00))
    else $error("rearm mark outlived its source");

  a_evt_query_all: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && cmd_op == srq_pkg::CMD_EVT_RD_ALL) |=> rsp_valid && (rsp_data == $past(evt.value)))
    else $error("event status query answer wrong");

  a_evt_query_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && cmd_op == srq_pkg::CMD_EVT_RD_BIT) |=>
      rsp_valid && (rsp_data == {7'h00, $past(evt.value[cmd_index])}))
    else $error("event bit query answer wrong");

  a_summary_map: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> (summary_reg[srq_pkg::GAUGE_BIT] == $past(gauge_summary)) &&
      (summary_reg[srq_pkg::ERR_BIT] == $past(error_summary)) &&
      (summary_reg[srq_pkg::PROC_BIT] == $past(process_control_summary)))
    else $error("summary bit map wrong");

  a_evt_clear_all: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && cmd_op == srq_pkg::CMD_EVT_RD_ALL) |=> (evt.value == $past(event_set)))
    else $error("event status not cleared by whole query");

  a_evt_clear_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd_valid && cmd_op == srq_pkg::CMD_EVT_RD_BIT) |=>
      (evt.value[$past(cmd_index)] == $past(event_set[cmd_index])))
    else $error("event bit not cleared by bit query");

endmodule // service_request

// ==== tb/poll_ctrl.sv ====
// model: bus controller that serial polls when it sees a service request
module poll_ctrl (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic poll_en,
  input wire logic srq,
  output logic serial_poll
);
  timeunit 1ns;
  timeprecision 1ns;
  logic poll_next;
  // one pulse per request, then a gap so the request can drop before the next look
  always_comb begin
    poll_next = poll_en & srq & ~serial_poll;
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_poll <= 1'b0;
    end else begin
      serial_poll <= poll_next;
    end
  end
endmodule // poll_ctrl

// ==== tb/tb_top.sv ====
// testbench: command sequences against the service request logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  srq_pkg::cmd_t cmd_op = srq_pkg::CMD_MASK_WR_ALL;
  logic [2:0] cmd_index = 3'h0;
  logic [7:0] cmd_data = 8'h00;
  logic proc_in = 1'b0;
  logic err_in = 1'b0;
  logic gauge_in = 1'b0;
  logic [7:0] event_set = 8'h00;
  logic poll_en = 1'b0;
  logic serial_poll;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic [7:0] summary_status;
  logic srq;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  service_request dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_index(cmd_index), .cmd_data(cmd_data), .process_control_summary(proc_in),
    .error_summary(err_in), .gauge_summary(gauge_in), .event_set(event_set), .serial_poll(serial_poll),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .summary_status(summary_status),
    .service_request_out(srq));
  poll_ctrl partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .poll_en(poll_en), .srq(srq),
    .serial_poll(serial_poll));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // command held for one edge; the answer is looked at just after that same edge
  task automatic send(input srq_pkg::cmd_t op, input logic [2:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_index <= idx;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic query(input string n, input srq_pkg::cmd_t op, input logic [2:0] idx, input logic [7:0] e);
    send(op, idx, 8'h00);
    chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
    chk(n, e, rsp_data);
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(1);
    chk("srq", 8'h00, {7'h00, srq});
    query("mask", srq_pkg::CMD_MASK_RD_ALL, 3'h0, srq_pkg::MASK_RESET);
    send(srq_pkg::CMD_MASK_WR_ALL, 3'h0, 8'h28);
    query("mask", srq_pkg::CMD_MASK_RD_ALL, 3'h0, 8'h28);
    send(srq_pkg::CMD_MASK_WR_BIT, 3'h3, 8'hfe);
    query("mask", srq_pkg::CMD_MASK_RD_ALL, 3'h0, 8'h20);
    query("mask bit", srq_pkg::CMD_MASK_RD_BIT, 3'h5, 8'h01);
    query("mask bit", srq_pkg::CMD_MASK_RD_BIT, 3'h3, 8'h00);
    send(srq_pkg::CMD_MASK_WR_ALL, 3'h0, 8'h04);
    @(posedge ref_clk);
    gauge_in <= 1'b1;
    tick(2);
    chk("summary", 8'h04, summary_status);
    chk("srq", 8'h01, {7'h00, srq});
    @(posedge ref_clk);
    poll_en <= 1'b1;
    tick(2);
    chk("srq", 8'h00, {7'h00, srq});
    // polls stop here, so a second request would stand and be seen
    @(posedge ref_clk);
    poll_en <= 1'b0;
    tick(6);
    chk("srq", 8'h00, {7'h00, srq});
    @(posedge ref_clk);
    gauge_in <= 1'b0;
    tick(2);
    @(posedge ref_clk);
    gauge_in <= 1'b1;
    tick(2);
    chk("srq", 8'h01, {7'h00, srq});
    @(posedge ref_clk);
    poll_en <= 1'b1;
    tick(2);
    chk("srq", 8'h00, {7'h00, srq});
    @(posedge ref_clk);
    poll_en <= 1'b0;
    err_in <= 1'b1;
    proc_in <= 1'b1;
    tick(3);
    chk("summary", 8'h07, summary_status);
    chk("srq", 8'h00, {7'h00, srq});
    send(srq_pkg::CMD_MASK_WR_BIT, 3'h1, 8'h01);
    tick(2);
    chk("srq", 8'h01, {7'h00, srq});
    @(posedge ref_clk);
    event_set <= 8'h11;
    @(posedge ref_clk);
    event_set <= 8'h00;
    tick(1);
    chk("summary", 8'h27, summary_status);
    query("event", srq_pkg::CMD_EVT_RD_ALL, 3'h0, 8'h11);
    query("event", srq_pkg::CMD_EVT_RD_ALL, 3'h0, 8'h00);
    @(posedge ref_clk);
    event_set <= 8'h06;
    @(posedge ref_clk);
    event_set <= 8'h00;
    query("event bit", srq_pkg::CMD_EVT_RD_BIT, 3'h1, 8'h01);
    query("event", srq_pkg::CMD_EVT_RD_ALL, 3'h0, 8'h04);
    finish_test();
  end
endmodule // tb_top
